// [shared/dmacp_map.svh]
`ifndef DMACP_MAP_SVH
`define DMACP_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define DMACP_CELL_BYTE_COUNT_OFS     8'h00
`define DMACP_CELL_PROGRESS_COUNT_OFS 8'h04
`define DMACP_MATCH_BYTE_OFS          8'h08
`define DMACP_MODE_CTRL_OFS           8'h0C
`define DMACP_STATUS_OFS              8'h10

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define DMACP_MODE_DETECT_BIT   0
`define DMACP_MODE_TERM_BIT     1
`define DMACP_MODE_ENABLE_BIT   2
`define DMACP_CELL_SIZE_RST     16'h0000
`define DMACP_MATCH_BYTE_RST    8'h00
`define DMACP_FULL_CELL         17'h10000

`endif

// [shared/dmacp_pkg.sv]
package dmacp_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dmacp_bus_req_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } dmacp_beat_type;

    typedef enum logic [2:0] {
        DMACP_IDLE = 3'b001,
        DMACP_MOVE = 3'b010,
        DMACP_DONE = 3'b100
    } dmacp_state_type;

    typedef struct packed {
        dmacp_state_type state;
        logic [15:0]     cell_size_field;
        logic [15:0]     cell_progress_field;
        logic [7:0]      match_byte_field;
        logic [2:0]      mode;
        logic            terminated;
        logic            cell_done;
        logic [31:0]     rdata;
        logic [1:0]      buf_cnt;
        logic [7:0]      buf0;
        logic [7:0]      buf1;
    } dmacp_state_all_type;

endpackage

// [rtl/dmacp_channel.sv]
`timescale 1ns/1ps
`include "dmacp_map.svh"
// Function
// - Cell size sets bytes per trigger, zero=65536
// - Read-only progress counter of bytes since trigger
// - Pattern detect match clears progress counter
// - Match byte used only in detect and terminate modes
// - Match byte bits 31-8 read zero
// - Upper 16 bits zero, reset clears all
module dmacp_channel
    import dmacp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    input  wire logic        trigger,
    input  wire logic        src_valid,
    input  wire logic [7:0]  src_data,
    output logic             src_ready,
    output logic             dst_valid,
    output logic      [7:0]  dst_data,
    input  wire logic        dst_ready,
    output logic             cell_done,
    output logic             pattern_hit,
    output logic             terminated
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dmacp_state_all_type s_q;
    dmacp_state_all_type s_d;
    logic                take;
    logic                give;
    logic                match;
    logic [16:0]         target;

    function automatic logic [16:0] cell_target(input logic [15:0] sz);
        cell_target = (sz == 16'h0000) ? `DMACP_FULL_CELL : {1'b0, sz};
    endfunction

    assign target      = cell_target(s_q.cell_size_field);
    // Accept only while moving and room remains in the two-entry buffer
    assign src_ready   = (s_q.state == DMACP_MOVE) && (s_q.buf_cnt != 2'h2);
    assign take        = src_valid && src_ready;
    assign dst_valid   = (s_q.buf_cnt != 2'h0);
    assign dst_data    = s_q.buf0;
    assign give        = dst_valid && dst_ready;
    assign match       = take && (src_data == s_q.match_byte_field);
    assign pattern_hit = match && (s_q.mode[`DMACP_MODE_DETECT_BIT] |
                                   s_q.mode[`DMACP_MODE_TERM_BIT]);
    assign bus_rdata   = s_q.rdata;
    assign cell_done   = s_q.cell_done;
    assign terminated  = s_q.terminated;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [16:0] next_cnt;
        next_cnt = 17'h00000;
        s_d = s_q;
        s_d.cell_done = 1'b0;
        s_d.rdata = 32'h0000_0000;
        if (bus_wr) begin
            unique case (bus_addr)
                `DMACP_CELL_BYTE_COUNT_OFS:
                    s_d.cell_size_field = bus_wdata[15:0];
                `DMACP_MATCH_BYTE_OFS:
                    s_d.match_byte_field = bus_wdata[7:0];
                `DMACP_MODE_CTRL_OFS: begin
                    s_d.mode = bus_wdata[2:0];
                    s_d.terminated = 1'b0;
                end
                default: begin
                end
            endcase
        end
        if (bus_rd) begin
            unique case (bus_addr)
                `DMACP_CELL_BYTE_COUNT_OFS:
                    s_d.rdata = {16'h0000, s_q.cell_size_field};
                `DMACP_CELL_PROGRESS_COUNT_OFS:
                    s_d.rdata = {16'h0000, s_q.cell_progress_field};
                `DMACP_MATCH_BYTE_OFS:
                    s_d.rdata = {24'h000000, s_q.match_byte_field};
                `DMACP_MODE_CTRL_OFS:
                    s_d.rdata = {29'h0, s_q.mode};
                `DMACP_STATUS_OFS:
                    s_d.rdata = {27'h0, s_q.terminated, s_q.buf_cnt,
                                 s_q.state == DMACP_MOVE,
                                 s_q.state == DMACP_IDLE};
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end

        // Two-entry buffer: a stalled receiver keeps both words
        unique case ({take, give})
            2'b10: begin
                if (s_q.buf_cnt == 2'h0) s_d.buf0 = src_data;
                else s_d.buf1 = src_data;
                s_d.buf_cnt = s_q.buf_cnt + 2'h1;
            end
            2'b01: begin
                s_d.buf0 = s_q.buf1;
                s_d.buf_cnt = s_q.buf_cnt - 2'h1;
            end
            2'b11: begin
                if (s_q.buf_cnt == 2'h1) s_d.buf0 = src_data;
                else begin
                    s_d.buf0 = s_q.buf1;
                    s_d.buf1 = src_data;
                end
            end
            default: begin
            end
        endcase

        unique case (s_q.state)
            DMACP_IDLE: begin
                if (trigger && s_q.mode[`DMACP_MODE_ENABLE_BIT] &&
                    !s_q.terminated) begin
                    s_d.state = DMACP_MOVE;
                    s_d.cell_progress_field = 16'h0000;
                end
            end
            DMACP_MOVE: begin
                if (take) begin
                    next_cnt = {1'b0, s_q.cell_progress_field} + 17'h1;
                    if (match && s_q.mode[`DMACP_MODE_DETECT_BIT]) begin
                        s_d.cell_progress_field = 16'h0000;
                    end else if (next_cnt == target) begin
                        s_d.cell_progress_field = 16'h0000;
                    end else begin
                        s_d.cell_progress_field = next_cnt[15:0];
                    end
                    // Match byte ends the cell only in terminate mode
                    if (match && s_q.mode[`DMACP_MODE_TERM_BIT]) begin
                        s_d.terminated = 1'b1;
                        s_d.state = DMACP_DONE;
                    end else if (next_cnt == target) begin
                        s_d.state = DMACP_DONE;
                    end
                end
            end
            DMACP_DONE: begin
                s_d.cell_done = 1'b1;
                s_d.state = DMACP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.state               <= DMACP_IDLE;
            s_q.cell_size_field     <= `DMACP_CELL_SIZE_RST;
            s_q.cell_progress_field <= 16'h0000;
            s_q.match_byte_field    <= `DMACP_MATCH_BYTE_RST;
            s_q.mode                <= 3'h0;
            s_q.terminated          <= 1'b0;
            s_q.cell_done           <= 1'b0;
            s_q.rdata               <= 32'h0000_0000;
            s_q.buf_cnt             <= 2'h0;
            s_q.buf0                <= 8'h00;
            s_q.buf1                <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_detect_clears_progress: assert property (
        (s_q.state == DMACP_MOVE && match && s_q.mode[0])
        |=> (s_q.cell_progress_field == 16'h0000))
        else $error("progress not cleared on pattern detect");

    a_progress_counts_up: assert property (
        (s_q.state == DMACP_MOVE && take && !match &&
         ({1'b0, s_q.cell_progress_field} + 17'h1) != target)
        |=> (s_q.cell_progress_field ==
             $past(s_q.cell_progress_field) + 16'h1))
        else $error("progress did not advance by one");

    a_cell_end_wraps: assert property (
        (s_q.state == DMACP_MOVE && take &&
         ({1'b0, s_q.cell_progress_field} + 17'h1) == target)
        |=> (s_q.cell_progress_field == 16'h0000) ##1 cell_done)
        else $error("cell end not handled");

    a_pattern_read_zero: assert property (
        (bus_rd && bus_addr == `DMACP_MATCH_BYTE_OFS)
        |=> (bus_rdata[31:8] == 24'h000000))
        else $error("match byte upper bits not zero");

    a_size_read_back: assert property (
        (bus_rd && bus_addr == `DMACP_CELL_BYTE_COUNT_OFS)
        |=> (bus_rdata == {16'h0000, $past(s_q.cell_size_field)}))
        else $error("cell size read wrong");

    a_progress_read: assert property (
        (bus_rd && bus_addr == `DMACP_CELL_PROGRESS_COUNT_OFS)
        |=> (bus_rdata == {16'h0000, $past(s_q.cell_progress_field)}))
        else $error("progress read wrong");

    a_term_only_mode: assert property (
        $rose(terminated) |-> $past(s_q.mode[1]) && $past(match))
        else $error("termination outside terminate mode");

    a_buffer_no_loss: assert property (
        (dst_valid && !dst_ready) |=> (dst_valid && $stable(dst_data)))
        else $error("buffered word lost under stall");

    // ------------------------------------------------------------------
    // Register bus and sequencing guards
    // ------------------------------------------------------------------
    // Read data must be zero outside its one-cycle slot, so a master
    // that samples late sees zero rather than a stale word
    a_rdata_idle_zero: assert property (
        !bus_rd |=> (bus_rdata == 32'h0000_0000))
        else $error("read data not zero outside read slot");

    a_size_write_lands: assert property (
        (bus_wr && bus_addr == `DMACP_CELL_BYTE_COUNT_OFS)
        |=> (s_q.cell_size_field == $past(bus_wdata[15:0])))
        else $error("cell size write lost");

    a_match_write_lands: assert property (
        (bus_wr && bus_addr == `DMACP_MATCH_BYTE_OFS)
        |=> (s_q.match_byte_field == $past(bus_wdata[7:0])))
        else $error("match byte write lost");

    a_progress_read_only: assert property (
        (bus_wr && bus_addr == `DMACP_CELL_PROGRESS_COUNT_OFS &&
         s_q.state == DMACP_IDLE && !trigger)
        |=> $stable(s_q.cell_progress_field))
        else $error("progress counter written by software");

    a_start_clears: assert property (
        (s_q.state == DMACP_IDLE && trigger &&
         s_q.mode[`DMACP_MODE_ENABLE_BIT] && !s_q.terminated)
        |=> (s_q.state == DMACP_MOVE && s_q.cell_progress_field == 16'h0))
        else $error("cell start did not clear progress");

    a_ready_only_moving: assert property (
        (s_q.state != DMACP_MOVE) |-> !src_ready)
        else $error("byte accepted outside a cell");

    a_done_one_pulse: assert property (
        cell_done |=> !cell_done)
        else $error("cell done longer than one cycle");

    // A terminated channel must stay parked until software rearms it
    a_term_stays_idle: assert property (
        (s_q.state == DMACP_IDLE && s_q.terminated && !bus_wr)
        |=> (s_q.state == DMACP_IDLE))
        else $error("terminated channel restarted");

    a_match_ignored: assert property (
        (take && !s_q.mode[`DMACP_MODE_TERM_BIT] && !bus_wr)
        |=> $stable(terminated))
        else $error("match byte used outside terminate mode");

    a_buffer_bound: assert property (
        s_q.buf_cnt != 2'h3)
        else $error("buffer count beyond two entries");

    c_full_cell: cover property (cell_done);
    c_detect_hit: cover property (pattern_hit && s_q.mode[0]);
    c_term_hit: cover property ($rose(terminated));
    c_buffer_full: cover property (s_q.buf_cnt == 2'h2);

endmodule // dmacp_channel

// [tb/dmacp_partner.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Byte source and sink beside the channel
// ------------------------------------------------------------
module dmacp_partner (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        src_ready,
    output logic             src_valid,
    output logic      [7:0]  src_data,
    input  wire logic        dst_valid,
    input  wire logic [7:0]  dst_data,
    output logic             dst_ready,
    input  wire logic        stall,
    input  wire logic        slow,
    input  wire logic [31:0] limit,
    output logic      [31:0] rx_count,
    output logic      [31:0] order_errs
);
    logic [31:0] sent_q;
    logic        tgl_q;
    logic [7:0]  nxt;

    assign nxt       = 8'h10 + sent_q[7:0];
    assign src_valid = rst_n && (sent_q < limit);
    // Idle data shows the inverse of the last byte, so nothing stale passes
    assign src_data  = src_valid ? nxt : ~(nxt - 8'h01);
    assign dst_ready = rst_n && !stall && (!slow || tgl_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sent_q     <= 32'h0;
            tgl_q      <= 1'b0;
            rx_count   <= 32'h0;
            order_errs <= 32'h0;
        end else begin
            tgl_q <= ~tgl_q;
            if (src_valid && src_ready)
                sent_q <= sent_q + 32'h1;
            if (dst_valid && dst_ready) begin
                rx_count <= rx_count + 32'h1;
                if (dst_data !== 8'h10 + rx_count[7:0])
                    order_errs <= order_errs + 32'h1;
            end
        end
    end
endmodule // dmacp_partner

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
    logic        clk, rst_n, bus_wr, bus_rd, trigger, stall, slow;
    logic [7:0]  bus_addr, src_data, dst_data;
    logic [31:0] bus_wdata, bus_rdata, limit, rx_count, order_errs;
    logic        src_valid, src_ready, dst_valid, dst_ready;
    logic        cell_done, terminated, pattern_hit;
    int          hit_count = 0;
    int          fail_count = 0;
    int          checked = 0;

    dmacp_channel dmacp_channel_inst (.clk(clk), .rst_n(rst_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .trigger(trigger),
        .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
        .dst_valid(dst_valid), .dst_data(dst_data), .dst_ready(dst_ready),
        .cell_done(cell_done), .pattern_hit(pattern_hit),
        .terminated(terminated));
    dmacp_partner dmacp_partner_inst (.clk(clk), .rst_n(rst_n),
        .src_ready(src_ready), .src_valid(src_valid), .src_data(src_data),
        .dst_valid(dst_valid), .dst_data(dst_data), .dst_ready(dst_ready),
        .stall(stall), .slow(slow), .limit(limit), .rx_count(rx_count),
        .order_errs(order_errs));

    always #4 clk = ~clk;
    always @(posedge clk)
        if (pattern_hit === 1'b1) hit_count++;

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a,
                          input logic [31:0] e);
        @(posedge clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd   <= 1'b0;
        #1 chk(n, bus_rdata, e);
    endtask
    task automatic fire();
        @(posedge clk);
        trigger <= 1'b1;
        @(posedge clk);
        trigger <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bounded so a stuck cell ends the run instead of hanging it
    task automatic wait_done(input int lim);
        for (int i = 0; i < lim && cell_done !== 1'b1; i++)
            @(posedge clk) #1;
        if (cell_done !== 1'b1) begin
            fail_count++;
            $display("[ERR] cell_done expected 1 seen timeout");
            close_out();
        end
    endtask

    initial begin
        {clk, rst_n, bus_wr, bus_rd, trigger, stall, slow} = 7'h00;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        limit = 32'h0;
        idle(5);
        rst_n <= 1'b1;
        rd_chk("size", 8'h00, 32'h0);
        rd_chk("progress", 8'h04, 32'h0);
        rd_chk("match", 8'h08, 32'h0);
        rd_chk("unmapped", 8'h14, 32'h0);
        wr(8'h00, 32'hFFFF_0008);
        rd_chk("size", 8'h00, 32'h0000_0008);
        wr(8'h08, 32'hFFFF_FF1A);
        rd_chk("match", 8'h08, 32'h0000_001A);
        wr(8'h04, 32'h0000_0033);
        rd_chk("progress", 8'h04, 32'h0);
        $display("Test registers done");
        wr(8'h0C, 32'h0000_0004);
        stall <= 1'b1;
        limit <= 32'd4;
        fire();
        idle(10);
        #1 chk("src_ready", {31'h0, src_ready}, 32'h0);
        @(posedge clk);
        stall <= 1'b0;
        slow  <= 1'b1;
        idle(20);
        rd_chk("progress", 8'h04, 32'h4);
        limit <= 32'd8;
        wait_done(100);
        rd_chk("progress", 8'h04, 32'h0);
        idle(10);
        chk("rx_count", rx_count, 32'd8);
        slow <= 1'b0;
        $display("Test plain cell done");
        wr(8'h0C, 32'h0000_0005);
        limit <= 32'd12;
        fire();
        idle(10);
        rd_chk("progress", 8'h04, 32'h1);
        limit <= 32'd19;
        wait_done(100);
        rd_chk("progress", 8'h04, 32'h0);
        chk("hit_count", hit_count, 32'd1);
        $display("Test detect done");
        wr(8'h08, 32'h0000_0025);
        wr(8'h0C, 32'h0000_0006);
        limit <= 32'd22;
        fire();
        wait_done(100);
        chk("terminated", {31'h0, terminated}, 32'h1);
        fire();
        idle(5);
        rd_chk("status", 8'h10, 32'h0000_0011);
        wr(8'h0C, 32'h0000_0004);
        rd_chk("status", 8'h10, 32'h0000_0001);
        $display("Test terminate done");
        wr(8'h00, 32'h0);
        limit <= 32'd65558;
        fire();
        wait_done(70000);
        idle(10);
        chk("rx_count", rx_count, 32'd65558);
        chk("order_errs", order_errs, 32'h0);
        chk("hit_count", hit_count, 32'd2);
        $display("Test full cell done");
        close_out();
    end
endmodule // tb
